// ---- uvrc_pkg.sv ----
// Purpose: shared constants for the undervoltage reset control block
// Assumes: 250 MHz system clock; 8-bit register port with a 2-bit word address
// Notes:   each figure appears here once and is used by name in uvrc_top; the checker and bench repeat the codes as literals
package uvrc_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 2;
   localparam int DATA_W = 8;
   localparam logic [1:0] ADDR_THRESHOLD = 2'h0;
   localparam logic [1:0] ADDR_RESET_CAUSE = 2'h1;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // ---------------------------------------------------------------
   // threshold select codes
   // ---------------------------------------------------------------
   localparam logic [7:0] THR_CODE_2V10 = 8'h55;
   localparam logic [7:0] THR_CODE_2V55 = 8'h33;
   localparam logic [7:0] THR_CODE_3V15 = 8'h99;
   localparam logic [7:0] THR_CODE_3V80 = 8'hAA;
   localparam logic [7:0] THR_RESET = THR_CODE_2V10;

   // ---------------------------------------------------------------
   // watchdog enable codes
   // ---------------------------------------------------------------
   localparam int WDC_CODE_W = 5;
   localparam logic [4:0] WDC_CODE_DISABLE = 5'h15;
   localparam logic [4:0] WDC_CODE_ENABLE = 5'h0A;

   // ---------------------------------------------------------------
   // reset cause register fields
   // ---------------------------------------------------------------
   localparam int CAUSE_WDC_BIT = 0;
   localparam int CAUSE_THR_BIT = 1;
   localparam int CAUSE_UV_BIT = 2;
   localparam int CAUSE_KEEP_ON_BIT = 7;
   localparam int CAUSE_RSVD_LO = 3;
   localparam int CAUSE_RSVD_HI = 6;
   localparam logic [3:0] CAUSE_RSVD_VALUE = 4'h0;
   localparam logic FLAG_RESET = 1'b0;
   localparam logic KEEP_ON_RESET = 1'b0;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int UV_QUALIFY_TIME_NS = 120000;
   localparam int SW_RESET_DELAY_NS = 45000;
   // least times: round up to whole cycles
   localparam int UV_QUALIFY_CYCLES = (UV_QUALIFY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SW_RESET_CYCLES = (SW_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // qualification timer channels
   // ---------------------------------------------------------------
   localparam int NUM_TIMERS = 3;
   localparam int TMR_UV = 0;
   localparam int TMR_THR = 1;
   localparam int TMR_WDC = 2;

   typedef enum logic [1:0] {
      SEQ_POR_INIT,
      SEQ_RUN,
      SEQ_FULL_RESET
   } uvrc_seq_t;

endpackage

// ---- uvrc_qual_if.sv ----
// Purpose: link between the controller and one qualification timer
// Assumes: both ends on core_clk_in
// Notes:   fire is a one-cycle pulse per continuous trigger assertion
`timescale 1ns/1ps
`default_nettype none
interface uvrc_qual_if;
   logic trigger;
   logic fire;
   modport owner (output trigger, input fire);
   modport timer (input trigger, output fire);
endinterface
`default_nettype wire

// ---- uvrc_qual_timer.sv ----
// Purpose: measures how long a condition has held and pulses once when it reaches a count
// Assumes: trigger is synchronous to core_clk_in
// Notes:   count restarts from zero whenever trigger drops
`timescale 1ns/1ps
`default_nettype none
module uvrc_qual_timer #(
   parameter int COUNT = 1
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   uvrc_qual_if.timer q
);
   localparam int CNT_W = $clog2(COUNT + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(COUNT - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   logic [CNT_W-1:0] cnt;
   logic done;
   logic fire_q;

   // ---------------------------------------------------------------
   // counter
   // ---------------------------------------------------------------
   // done blocks a second pulse while the same condition persists
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt <= CNT_ZERO;
         done <= 1'b0;
         fire_q <= 1'b0;
      end else if (!q.trigger) begin
         cnt <= CNT_ZERO;
         done <= 1'b0;
         fire_q <= 1'b0;
      end else if (!done && cnt == CNT_LAST) begin
         done <= 1'b1;
         fire_q <= 1'b1;
      end else begin
         if (!done) begin
            cnt <= cnt + CNT_ONE;
         end
         fire_q <= 1'b0;
      end
   end

   assign q.fire = fire_q;
endmodule
`default_nettype wire

// ---- uvrc_top.sv ----
// Purpose: undervoltage reset control: qualifies supply-low, checks control codes,
//          keeps reset-cause and status flags, sequences reset outputs
// Assumes: power-on reset on rst_n_in; mode and watchdog inputs come from core_clk_in logic
// Notes:   the watchdog counter and the analogue comparator live outside
//
// Function
// - undervoltage monitor runs in normal and slow modes without any enable
// - supply-low held past qualification time causes full reset and sets flag
// - supply-low shorter than the qualification time is ignored
// - only four threshold codes are legal: 55, 33, 99, AA hex
// - illegal threshold code resets after software-reset delay and restores register
// - threshold register powers up as 55 hex, lowest threshold
// - qualified undervoltage reset leaves threshold register unchanged
// - illegal threshold code sets cause bit 1; only software zero clears
// - undervoltage reset sets cause bit 2; only software zero clears
// - monitor is disabled in idle or sleep mode
// - watchdog timeout while running gives full reset and sets timeout flag
// - watchdog timeout in sleep or idle clears only pc and stack pointer
// - timeout and power-down flags follow the reset kind
// - power-on disables interrupts and switches timers off
// - power-on clears the watchdog counter which then runs
// - power-on makes all port pins inputs
// - power-on zeroes the program counter, stack pointer to stack top
// - illegal watchdog enable code resets after software-reset delay
// - illegal watchdog enable code sets cause bit 0; only software zero clears
`timescale 1ns/1ps
`default_nettype none
module uvrc_top #(
   parameter int UV_QUALIFY_CYCLES = uvrc_pkg::UV_QUALIFY_CYCLES,
   parameter int SW_RESET_CYCLES = uvrc_pkg::SW_RESET_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // analogue supply monitor, asynchronous
   input wire logic supply_low_in,
   // operating mode and watchdog
   input wire logic sleep_mode_in,
   input wire logic idle_mode_in,
   input wire logic watchdog_timeout_in,
   input wire logic [uvrc_pkg::WDC_CODE_W-1:0] watchdog_enable_code_in,
   input wire logic status_flags_clear_in,
   // register port
   input wire logic [uvrc_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [uvrc_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [uvrc_pkg::DATA_W-1:0] reg_rdata_out,
   // reset and initialisation
   output logic system_reset_out,
   output logic pc_sp_init_out,
   output logic interrupts_disable_out,
   output logic timers_off_out,
   output logic watchdog_clear_out,
   output logic ports_input_out,
   // state
   output logic undervoltage_monitor_active_out,
   output logic [uvrc_pkg::DATA_W-1:0] threshold_select_code_out,
   output logic idle_sysclk_keep_on_out,
   output logic timeout_status_flag_out,
   output logic power_down_status_flag_out
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic supply_low_meta;
   logic supply_low_sync;
   logic low_power;
   logic monitor_active;
   logic [uvrc_pkg::DATA_W-1:0] threshold_select_register;
   logic threshold_code_legal;
   logic watchdog_code_legal;
   logic undervoltage_reset_flag;
   logic illegal_threshold_code_flag;
   logic watchdog_control_reset_flag;
   logic idle_sysclk_keep_on;
   logic timeout_status_flag;
   logic power_down_status_flag;
   logic uv_fire;
   logic thr_fire;
   logic wdc_fire;
   logic wdt_run_evt;
   logic wdt_sleep_evt;
   logic full_evt;
   logic restore_evt;
   logic wr_threshold;
   logic wr_cause;
   logic rd_threshold;
   logic rd_cause;
   logic [uvrc_pkg::DATA_W-1:0] cause_view;
   uvrc_pkg::uvrc_seq_t seq_state;
   uvrc_pkg::uvrc_seq_t next_seq_state;
   logic [uvrc_pkg::NUM_TIMERS-1:0] timer_trigger;
   logic [uvrc_pkg::NUM_TIMERS-1:0] timer_fire;

   // ---------------------------------------------------------------
   // supply-low synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         supply_low_meta <= 1'b0;
         supply_low_sync <= 1'b0;
      end else begin
         supply_low_meta <= supply_low_in;
         supply_low_sync <= supply_low_meta;
      end
   end

   // ---------------------------------------------------------------
   // mode gating and code checks
   // ---------------------------------------------------------------
   assign low_power = sleep_mode_in | idle_mode_in;
   // no software enable exists; the mode alone decides
   assign monitor_active = !low_power;

   always_comb begin
      case (threshold_select_register)
         uvrc_pkg::THR_CODE_2V10: threshold_code_legal = 1'b1;
         uvrc_pkg::THR_CODE_2V55: threshold_code_legal = 1'b1;
         uvrc_pkg::THR_CODE_3V15: threshold_code_legal = 1'b1;
         uvrc_pkg::THR_CODE_3V80: threshold_code_legal = 1'b1;
         default: threshold_code_legal = 1'b0;
      endcase
   end

   assign watchdog_code_legal = (watchdog_enable_code_in == uvrc_pkg::WDC_CODE_DISABLE) ||
                                (watchdog_enable_code_in == uvrc_pkg::WDC_CODE_ENABLE);

   // ---------------------------------------------------------------
   // qualification timers
   // ---------------------------------------------------------------
   // a short supply dip drops the trigger and restarts the count, so it never fires
   assign timer_trigger[uvrc_pkg::TMR_UV] = supply_low_sync & monitor_active;
   assign timer_trigger[uvrc_pkg::TMR_THR] = !threshold_code_legal;
   assign timer_trigger[uvrc_pkg::TMR_WDC] = !watchdog_code_legal;

   genvar gi;
   generate
      for (gi = 0; gi < uvrc_pkg::NUM_TIMERS; gi++) begin : g_timer
         localparam int TCOUNT = (gi == uvrc_pkg::TMR_UV) ? UV_QUALIFY_CYCLES : SW_RESET_CYCLES;
         uvrc_qual_if q_if ();
         assign q_if.trigger = timer_trigger[gi];
         assign timer_fire[gi] = q_if.fire;
         uvrc_qual_timer #(
            .COUNT(TCOUNT)
         ) u_timer (
            .core_clk_in(core_clk_in),
            .rst_n_in(rst_n_in),
            .q(q_if)
         );
      end
   endgenerate

   assign uv_fire = timer_fire[uvrc_pkg::TMR_UV];
   assign thr_fire = timer_fire[uvrc_pkg::TMR_THR];
   assign wdc_fire = timer_fire[uvrc_pkg::TMR_WDC];

   // ---------------------------------------------------------------
   // reset events
   // ---------------------------------------------------------------
   assign wdt_run_evt = watchdog_timeout_in & !low_power;
   assign wdt_sleep_evt = watchdog_timeout_in & low_power;
   assign full_evt = uv_fire | thr_fire | wdc_fire | wdt_run_evt;
   // an undervoltage reset alone keeps the threshold code
   assign restore_evt = thr_fire | wdc_fire | wdt_run_evt;

   // ---------------------------------------------------------------
   // register port decode
   // ---------------------------------------------------------------
   assign wr_threshold = reg_wr_in && (reg_addr_in == uvrc_pkg::ADDR_THRESHOLD);
   assign wr_cause = reg_wr_in && (reg_addr_in == uvrc_pkg::ADDR_RESET_CAUSE);
   assign rd_threshold = reg_rd_in && (reg_addr_in == uvrc_pkg::ADDR_THRESHOLD);
   assign rd_cause = reg_rd_in && (reg_addr_in == uvrc_pkg::ADDR_RESET_CAUSE);

   // ---------------------------------------------------------------
   // threshold select register
   // ---------------------------------------------------------------
   // an illegal value is stored as written; the checker then reacts to it
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         threshold_select_register <= uvrc_pkg::THR_RESET;
      end else if (restore_evt) begin
         threshold_select_register <= uvrc_pkg::THR_RESET;
      end else if (wr_threshold) begin
         threshold_select_register <= reg_wdata_in;
      end
   end

   // ---------------------------------------------------------------
   // reset cause flags
   // ---------------------------------------------------------------
   // hardware set wins over a software clear in the same cycle; writing one changes nothing
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         undervoltage_reset_flag <= uvrc_pkg::FLAG_RESET;
      end else if (uv_fire) begin
         undervoltage_reset_flag <= 1'b1;
      end else if (wr_cause && !reg_wdata_in[uvrc_pkg::CAUSE_UV_BIT]) begin
         undervoltage_reset_flag <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         illegal_threshold_code_flag <= uvrc_pkg::FLAG_RESET;
      end else if (thr_fire) begin
         illegal_threshold_code_flag <= 1'b1;
      end else if (wr_cause && !reg_wdata_in[uvrc_pkg::CAUSE_THR_BIT]) begin
         illegal_threshold_code_flag <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         watchdog_control_reset_flag <= uvrc_pkg::FLAG_RESET;
      end else if (wdc_fire) begin
         watchdog_control_reset_flag <= 1'b1;
      end else if (wr_cause && !reg_wdata_in[uvrc_pkg::CAUSE_WDC_BIT]) begin
         watchdog_control_reset_flag <= 1'b0;
      end
   end

   // plain storage for the idle clock control; full resets other than undervoltage return it to its power-on value
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         idle_sysclk_keep_on <= uvrc_pkg::KEEP_ON_RESET;
      end else if (restore_evt) begin
         idle_sysclk_keep_on <= uvrc_pkg::KEEP_ON_RESET;
      end else if (wr_cause) begin
         idle_sysclk_keep_on <= reg_wdata_in[uvrc_pkg::CAUSE_KEEP_ON_BIT];
      end
   end

   // ---------------------------------------------------------------
   // timeout and power-down status flags
   // ---------------------------------------------------------------
   // power-on clears both; undervoltage leaves both; sets beat the core's clear
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         timeout_status_flag <= 1'b0;
      end else if (watchdog_timeout_in) begin
         timeout_status_flag <= 1'b1;
      end else if (status_flags_clear_in) begin
         timeout_status_flag <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         power_down_status_flag <= 1'b0;
      end else if (wdt_sleep_evt) begin
         power_down_status_flag <= 1'b1;
      end else if (status_flags_clear_in) begin
         power_down_status_flag <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // reset sequencer
   // ---------------------------------------------------------------
   always_comb begin
      case (seq_state)
         uvrc_pkg::SEQ_POR_INIT: next_seq_state = full_evt ? uvrc_pkg::SEQ_FULL_RESET : uvrc_pkg::SEQ_RUN;
         uvrc_pkg::SEQ_RUN: next_seq_state = full_evt ? uvrc_pkg::SEQ_FULL_RESET : uvrc_pkg::SEQ_RUN;
         uvrc_pkg::SEQ_FULL_RESET: next_seq_state = full_evt ? uvrc_pkg::SEQ_FULL_RESET : uvrc_pkg::SEQ_RUN;
         default: next_seq_state = uvrc_pkg::SEQ_RUN;
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         seq_state <= uvrc_pkg::SEQ_POR_INIT;
      end else begin
         seq_state <= next_seq_state;
      end
   end

   // init pulses fire once in the cycle after power-on release and with every full reset; system_reset_out fires with full resets only
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         system_reset_out <= 1'b0;
         interrupts_disable_out <= 1'b0;
         timers_off_out <= 1'b0;
         watchdog_clear_out <= 1'b0;
         ports_input_out <= 1'b0;
      end else begin
         system_reset_out <= (next_seq_state == uvrc_pkg::SEQ_FULL_RESET);
         interrupts_disable_out <= (seq_state == uvrc_pkg::SEQ_POR_INIT) || full_evt;
         timers_off_out <= (seq_state == uvrc_pkg::SEQ_POR_INIT) || full_evt;
         watchdog_clear_out <= (seq_state == uvrc_pkg::SEQ_POR_INIT) || full_evt;
         ports_input_out <= (seq_state == uvrc_pkg::SEQ_POR_INIT) || full_evt;
      end
   end

   // the sleep-mode watchdog wake touches nothing but pc and stack pointer
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pc_sp_init_out <= 1'b0;
      end else begin
         pc_sp_init_out <= (seq_state == uvrc_pkg::SEQ_POR_INIT) || full_evt || wdt_sleep_evt;
      end
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always_comb begin
      cause_view = uvrc_pkg::READ_ZERO;
      cause_view[uvrc_pkg::CAUSE_KEEP_ON_BIT] = idle_sysclk_keep_on;
      cause_view[uvrc_pkg::CAUSE_RSVD_HI:uvrc_pkg::CAUSE_RSVD_LO] = uvrc_pkg::CAUSE_RSVD_VALUE;
      cause_view[uvrc_pkg::CAUSE_UV_BIT] = undervoltage_reset_flag;
      cause_view[uvrc_pkg::CAUSE_THR_BIT] = illegal_threshold_code_flag;
      cause_view[uvrc_pkg::CAUSE_WDC_BIT] = watchdog_control_reset_flag;
   end

   // data stand only in the cycle after the strobe; unmapped reads return zero
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= uvrc_pkg::READ_ZERO;
      end else if (rd_threshold) begin
         reg_rdata_out <= threshold_select_register;
      end else if (rd_cause) begin
         reg_rdata_out <= cause_view;
      end else begin
         reg_rdata_out <= uvrc_pkg::READ_ZERO;
      end
   end

   // ---------------------------------------------------------------
   // state outputs
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         undervoltage_monitor_active_out <= 1'b0;
      end else begin
         undervoltage_monitor_active_out <= monitor_active;
      end
   end

   assign threshold_select_code_out = threshold_select_register;
   assign idle_sysclk_keep_on_out = idle_sysclk_keep_on;
   assign timeout_status_flag_out = timeout_status_flag;
   assign power_down_status_flag_out = power_down_status_flag;

endmodule
`default_nettype wire

// ---- uvrc_top_sva.sv ----
// Purpose: port-level property checks for uvrc_top
// Assumes: one clock domain, active-low asynchronous reset
// Notes:   counters replace long repetitions; windows cover the synchroniser
`timescale 1ns/1ps
`default_nettype none
module uvrc_top_sva #(parameter int UV_QUALIFY_CYCLES = 4, parameter int SW_RESET_CYCLES = 6) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic supply_low_in,
   input wire logic sleep_mode_in,
   input wire logic idle_mode_in,
   input wire logic watchdog_timeout_in,
   input wire logic [4:0] watchdog_enable_code_in,
   input wire logic system_reset_out,
   input wire logic pc_sp_init_out,
   input wire logic interrupts_disable_out,
   input wire logic timers_off_out,
   input wire logic watchdog_clear_out,
   input wire logic ports_input_out,
   input wire logic undervoltage_monitor_active_out,
   input wire logic [7:0] threshold_select_code_out,
   input wire logic timeout_status_flag_out,
   input wire logic power_down_status_flag_out
);
   int low_n, thr_n, wdc_n;
   logic thr_bad, wdc_bad, awake;
   assign thr_bad = !(threshold_select_code_out inside {8'h55, 8'h33, 8'h99, 8'hAA});
   assign wdc_bad = !(watchdog_enable_code_in inside {5'h15, 5'h0A});
   assign awake = !sleep_mode_in && !idle_mode_in;
   // supply-low counts only while awake: the monitor sleeps too
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         low_n <= 0;
         thr_n <= 0;
         wdc_n <= 0;
      end else begin
         low_n <= (supply_low_in && awake) ? low_n + 1 : 0;
         thr_n <= thr_bad ? thr_n + 1 : 0;
         wdc_n <= wdc_bad ? wdc_n + 1 : 0;
      end
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   property p_uv_long;
      low_n == UV_QUALIFY_CYCLES + 2 |-> ##[1:3] (system_reset_out && $stable(threshold_select_code_out));
   endproperty
   a_uv_long: assert property (p_uv_long) else $error("long supply low gave no reset");
   property p_uv_short; $fell(supply_low_in) && low_n < UV_QUALIFY_CYCLES |-> !system_reset_out [*6]; endproperty
   a_uv_short: assert property (p_uv_short) else $error("short supply low gave a reset");
   property p_uv_sleep; (sleep_mode_in && supply_low_in) [*8] |-> !system_reset_out; endproperty
   a_uv_sleep: assert property (p_uv_sleep) else $error("reset while asleep");
   property p_mon;
      $past(rst_n_in) |-> undervoltage_monitor_active_out == $past(awake);
   endproperty
   a_mon: assert property (p_mon) else $error("monitor activity wrong");
   property p_wdt_run;
      watchdog_timeout_in && awake |=> system_reset_out && timeout_status_flag_out
         && power_down_status_flag_out == $past(power_down_status_flag_out);
   endproperty
   a_wdt_run: assert property (p_wdt_run) else $error("running timeout wrong");
   property p_wdt_idle;
      watchdog_timeout_in && !awake |=> pc_sp_init_out && !system_reset_out
         && timeout_status_flag_out && power_down_status_flag_out;
   endproperty
   a_wdt_idle: assert property (p_wdt_idle) else $error("low-power timeout wrong");
   property p_por;
      $rose(rst_n_in) |-> threshold_select_code_out == 8'h55 ##1 (interrupts_disable_out && timers_off_out
         && watchdog_clear_out && ports_input_out && pc_sp_init_out);
   endproperty
   a_por: assert property (p_por) else $error("power-on state wrong");
   property p_thr_bad;
      thr_n == SW_RESET_CYCLES |-> ##[0:3] (system_reset_out && threshold_select_code_out == 8'h55);
   endproperty
   a_thr_bad: assert property (p_thr_bad) else $error("bad threshold code not reset");
   property p_wdc_bad; wdc_n == SW_RESET_CYCLES |-> ##[0:3] system_reset_out; endproperty
   a_wdc_bad: assert property (p_wdc_bad) else $error("bad watchdog code not reset");
   c_uv: cover property (low_n == UV_QUALIFY_CYCLES + 2);
   c_idle: cover property (pc_sp_init_out && !system_reset_out);
   c_code: cover property (thr_n == SW_RESET_CYCLES);
endmodule
`default_nettype wire

// ---- uvrc_supply_model.sv ----
// Purpose: supply monitor stand-in, holds supply-low for len_in cycles
// Assumes: started from the bench clock
// Notes:   whole cycles only, no sub-cycle glitches
`timescale 1ns/1ps
`default_nettype none
module uvrc_supply_model (
   input wire logic core_clk_in,
   input wire logic go_in,
   input wire logic [7:0] len_in,
   output logic supply_low_out
);
   logic [7:0] left = 8'h00;
   always @(posedge core_clk_in) begin
      if (go_in) begin
         left <= len_in;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end
   assign supply_low_out = (left != 8'h00);
endmodule
`default_nettype wire

// ---- tb_undervoltage_reset_control.sv ----
// Purpose: self-checking bench for uvrc_top
// Assumes: short qualification and delay counts
// Notes:   register cases from a table, reset sources by hand
`timescale 1ns/1ps
`default_nettype none
module tb_undervoltage_reset_control;
   logic core_clk_in = 1'b0, rst_n_in = 1'b0;
   logic sleep = 1'b0, idle = 1'b0, wto = 1'b0, clr = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
   logic [4:0] wdc = 5'h0A;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00, len = 8'h00;
   logic low, srst, pcsp, tof, pdn, mon;
   logic [7:0] rdata, thr;
   int fails = 0, tests_run = 0, nrst = 0;
   logic [23:0] rows [7] = '{24'h0_33_33, 24'h0_99_99, 24'h0_55_55, 24'h1_FF_80, 24'h1_00_00, 24'h2_FF_00,
      24'h0_AA_AA};
   uvrc_supply_model i_uvrc_supply_model (.core_clk_in, .go_in(go), .len_in(len), .supply_low_out(low));
   uvrc_top #(.UV_QUALIFY_CYCLES(4), .SW_RESET_CYCLES(6)) i_uvrc_top (.core_clk_in,
      .rst_n_in, .supply_low_in(low), .sleep_mode_in(sleep), .idle_mode_in(idle), .watchdog_timeout_in(wto),
      .watchdog_enable_code_in(wdc), .status_flags_clear_in(clr), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .system_reset_out(srst), .pc_sp_init_out(pcsp),
      .interrupts_disable_out(), .timers_off_out(), .watchdog_clear_out(), .ports_input_out(),
      .undervoltage_monitor_active_out(mon), .threshold_select_code_out(thr), .idle_sysclk_keep_on_out(),
      .timeout_status_flag_out(tof), .power_down_status_flag_out(pdn));
   always #2 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) if (srst === 1'b1) nrst++;
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      addr <= a;
      wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk_in);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
      @(posedge core_clk_in);
      addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk_in);
      reg_rd <= 1'b0;
      #1 check(rdata, exp);
   endtask
   task automatic pulse(input logic s, input logic [7:0] n);
      @(posedge core_clk_in);
      {go, len, wto} <= {~s, n, s};
      @(posedge core_clk_in);
      {go, wto} <= 2'b00;
      #1;
   endtask
   task automatic wait_rst();
      int n = 0;
      while (srst !== 1'b1 && n < 40) begin
         @(posedge core_clk_in);
         #1 n++;
      end
      check({7'h00, srst}, 8'h01);
   endtask
   initial begin
      #20000 fails++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      #5 check(thr, 8'h55);
      rd_reg(2'h1, 8'h00);
      foreach (rows[i]) begin
         wr_reg(rows[i][17:16], rows[i][15:8]);
         rd_reg(rows[i][17:16], rows[i][7:0]);
      end
      pulse(1'b0, 8'h03);
      repeat (12) @(posedge core_clk_in);
      check(nrst[7:0], 8'h00);
      idle <= 1'b1;
      pulse(1'b1, 8'h00);
      check({thr[3:0], pcsp, srst, tof, pdn}, 8'hAB);
      @(posedge core_clk_in) {idle, sleep} <= 2'b01;
      pulse(1'b0, 8'h14);
      repeat (30) @(posedge core_clk_in);
      check({mon, nrst[6:0]}, 8'h00);
      @(posedge core_clk_in) sleep <= 1'b0;
      pulse(1'b0, 8'h14);
      wait_rst();
      check({thr[5:0], tof, pdn}, 8'hAB);
      repeat (25) @(posedge core_clk_in);
      rd_reg(2'h1, 8'h04);
      wr_reg(2'h1, 8'h00);
      rd_reg(2'h1, 8'h00);
      @(posedge core_clk_in) clr <= 1'b1;
      @(posedge core_clk_in) clr <= 1'b0;
      pulse(1'b1, 8'h00);
      check({4'h0, pcsp, srst, tof, pdn}, 8'h0E);
      wr_reg(2'h0, 8'h12);
      wr_reg(2'h0, 8'h33);
      repeat (12) @(posedge core_clk_in);
      check(nrst[7:0], 8'h02);
      wr_reg(2'h0, 8'h12);
      wait_rst();
      check(thr, 8'h55);
      rd_reg(2'h1, 8'h02);
      @(posedge core_clk_in) wdc <= 5'h00;
      wait_rst();
      repeat (20) @(posedge core_clk_in);
      rd_reg(2'h1, 8'h03);
      check(nrst[7:0], 8'h04);
      @(posedge core_clk_in) wdc <= 5'h0A;
      wr_reg(2'h1, 8'h00);
      rd_reg(2'h1, 8'h00);
      stop_test();
   end
endmodule
bind uvrc_top uvrc_top_sva #(.UV_QUALIFY_CYCLES(UV_QUALIFY_CYCLES), .SW_RESET_CYCLES(SW_RESET_CYCLES))
   i_uvrc_top_sva (.*);
`default_nettype wire
